// [rtl/ufec_event_control.sv]
// Event flags, masks, link control, device address and status of the USB function
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps

//
// Contract
// - Event flags set by hardware only
// - Transfer-ok flag is OR of endpoint flags
// - Correct means error-free, right toggle, acknowledged
// - Setup on busy endpoint 0 flags overrun
// - Bus faults set the fault flag
// - Idle over 3 ms sets sleep request
// - Idle check armed by reset, off while sleeping
// - Wake activity sets sleep-end on own vector
// - Bus reset sets flag, clears address
// - SOF token sets start-of-frame flag
// - Interrupt when flag, mask, and enabled
// - Resume and reset seen indicators readable
// - Resume bit drives resume signalling
// - Power-down bit turns regulator off
// - Force-sleep suspends, cleared by activity
// - Force-reset holds reset, event on release
// - Seven-bit address, cleared by link reset
// - Record token type of endpoint 0
// - Record endpoint number and direction
// - Fault cause as three-bit code
// - Fault code cleared with fault flag
// - Endpoint 0 correct transfer raises its flag
module ufec_event_control #(
  parameter int IDLE_CYCLES  = ufec_pkg::SUSPEND_IDLE_CYC,
  parameter int NUM_OK_FLAGS = 7
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  input  wire ufec_pkg::ufec_xfer_t   xfer,
  input  wire ufec_pkg::ufec_err_t    bus_err,
  input  wire logic                   sof_seen,
  input  wire logic                   bus_reset_seen,
  input  wire logic [NUM_OK_FLAGS-1:0] ep_ok_flags,
  input  wire logic                   line_idle,
  input  wire logic                   line_k,
  input  wire logic                   line_se0,
  input  wire logic                   cpu_irq_disable,
  output ufec_pkg::ufec_link_t        link,
  output logic [6:0]                  device_address,
  output logic                        regulator_ready,
  output logic                        ok_set,
  output logic [2:0]                  ok_ep,
  output logic                        ok_dir_in,
  output logic                        irq_request,
  output logic                        wake_irq_request
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (IDLE_CYCLES < 2) begin : g_bad_idle
    $error("IDLE_CYCLES must be at least 2");
  end
  if (NUM_OK_FLAGS < 1) begin : g_bad_flags
    $error("NUM_OK_FLAGS must be at least 1");
  end

  localparam int CNT_W = $clog2(IDLE_CYCLES + 1);
  localparam int SET_W = $clog2(ufec_pkg::REG_SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
  localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(ufec_pkg::REG_SETTLE_CYC);

  typedef enum logic [1:0] {
    UFEC_RUN,
    UFEC_SLEEP,
    UFEC_WAKE
  } ufec_link_state_t;

  typedef struct packed {
    logic [1:0]       idle_sync;
    logic [1:0]       k_sync;
    logic [1:0]       se0_sync;
    logic [5:0]       flags;
    logic [7:0]       mask;
    logic [3:0]       ctl;
    logic             resume_seen;
    logic [6:0]       addr;
    logic [7:0]       status;
    logic [2:0]       fault;
    logic             armed;
    logic [CNT_W-1:0] idle_cnt;
    logic [SET_W-1:0] settle_cnt;
    ufec_link_state_t lstate;
    logic [31:0]      rdata;
    logic             ok_set;
    logic [2:0]       ok_ep;
    logic             ok_dir_in;
    logic             irq;
    logic             wake_irq;
  } ufec_state_t;

  ufec_state_t st;
  ufec_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [2:0] fault_code(input ufec_pkg::ufec_err_t e);
    logic [2:0] c;
    c = ufec_pkg::FAULT_NONE;
    if (e.stuff) begin
      c = ufec_pkg::FAULT_STUFF;
    end else if (e.crc) begin
      c = ufec_pkg::FAULT_CRC;
    end else if (e.eop) begin
      c = ufec_pkg::FAULT_EOP;
    end else if (e.pid) begin
      c = ufec_pkg::FAULT_PID;
    end else if (e.mem) begin
      c = ufec_pkg::FAULT_MEM;
    end else if (e.timeout) begin
      c = ufec_pkg::FAULT_OTHER;
    end
    return c;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ufec_pkg::OFF_EVENT_FLAGS || a == ufec_pkg::OFF_EVENT_MASK ||
           a == ufec_pkg::OFF_LINK_CTRL   || a == ufec_pkg::OFF_DEV_ADDR   ||
           a == ufec_pkg::OFF_LAST_STATUS || a == ufec_pkg::OFF_FAULT_TYPE;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Combinational next state
  logic       acc_wr;
  logic       setup_rd;
  logic       any_err;
  logic       xfer_good;
  logic       setup_ovr;
  logic       link_rst;
  logic       idle_s;
  logic       k_s;
  logic       force_link_reset_release;
  logic [7:0] flags_view;
  logic [7:0] ctl_view;
  logic [5:0] set_ev;
  logic       wr_flags;
  logic       wr_mask;
  logic       wr_ctl;
  logic       wr_addr;
  logic       any_ok;

  always_comb begin
    next_st = st;

    // Pins cross into this domain; only the second stage is used below
    next_st.idle_sync = {st.idle_sync[0], line_idle};
    next_st.k_sync    = {st.k_sync[0], line_k};
    next_st.se0_sync  = {st.se0_sync[0], line_se0};
    idle_s = st.idle_sync[1];
    k_s    = st.k_sync[1];

    acc_wr   = psel && penable && pwrite;
    setup_rd = psel && !penable && !pwrite;
    // One strobe per register keeps the write decode in one place
    wr_flags = acc_wr && paddr == ufec_pkg::OFF_EVENT_FLAGS;
    wr_mask  = acc_wr && paddr == ufec_pkg::OFF_EVENT_MASK;
    wr_ctl   = acc_wr && paddr == ufec_pkg::OFF_LINK_CTRL;
    wr_addr  = acc_wr && paddr == ufec_pkg::OFF_DEV_ADDR;
    any_ok   = |ep_ok_flags;

    // Reads set up in an event cycle still see the old flags
    flags_view = {any_ok, 1'b0, st.flags};
    ctl_view   = {st.resume_seen, st.se0_sync[1], 2'b00, st.ctl};

    any_err   = |bus_err;
    xfer_good = xfer.done && xfer.acked && xfer.toggle_ok && !any_err;
    setup_ovr = xfer_good && xfer.ep == ufec_pkg::EP_CONTROL &&
                xfer.pid_hi == ufec_pkg::PID_SETUP_HI && ep_ok_flags[0];

    // Forced reset acts as a received bus reset for as long as it is held
    link_rst = bus_reset_seen || st.ctl[ufec_pkg::CTL_FORCE_RESET];
    // Letting go of a held force-reset is reported as a bus reset
    force_link_reset_release = wr_ctl && st.ctl[ufec_pkg::CTL_FORCE_RESET] && !pwdata[ufec_pkg::CTL_FORCE_RESET];

    // Hardware events of this cycle
    set_ev = 6'h00;
    set_ev[ufec_pkg::FLAG_SETUP_OVR] = setup_ovr;
    set_ev[ufec_pkg::FLAG_FAULT]     = any_err;
    set_ev[ufec_pkg::FLAG_SOF]       = sof_seen;
    set_ev[ufec_pkg::FLAG_BUS_RESET] = bus_reset_seen || force_link_reset_release;

    // Flags: a write can only clear, and a same-cycle event still sets
    if (wr_flags) begin
      next_st.flags = st.flags & pwdata[5:0];
      if (st.flags[ufec_pkg::FLAG_FAULT] && !pwdata[ufec_pkg::FLAG_FAULT]) begin
        next_st.fault = ufec_pkg::FAULT_NONE;
      end
    end
    // Mask bit 6 has no flag behind it and stays zero
    if (wr_mask) begin
      next_st.mask = pwdata[7:0] & ufec_pkg::MASK_WRITABLE;
    end
    if (wr_addr) begin
      next_st.addr = pwdata[6:0];
    end
    if (wr_ctl) begin
      next_st.ctl = pwdata[3:0];
    end

    // Fault code follows the fault event
    if (any_err) begin
      next_st.fault = fault_code(bus_err);
    end

    // Correct transfers: report endpoint and record status
    next_st.ok_set    = xfer_good;
    next_st.ok_ep     = xfer.ep;
    next_st.ok_dir_in = xfer.dir_in;
    // Endpoint codes past the last endpoint never reach the status
    if (xfer_good && !setup_ovr && xfer.ep <= ufec_pkg::EP_LAST) begin
      if (xfer.ep == ufec_pkg::EP_CONTROL) begin
        next_st.status = {xfer.pid_hi, 3'b000, xfer.ep};
      end else begin
        next_st.status = {2'b00, xfer.dir_in, 2'b00, xfer.ep};
      end
    end

    // Idle-line suspend detection
    if (st.armed && idle_s && st.lstate == UFEC_RUN) begin
      if (st.idle_cnt == IDLE_LAST) begin
        set_ev[ufec_pkg::FLAG_SLEEP_REQ] = 1'b1;
      end
      // Saturating, so one long idle stretch asks for sleep only once
      if (st.idle_cnt != CNT_W'(IDLE_CYCLES)) begin
        next_st.idle_cnt = st.idle_cnt + CNT_W'(1);
      end
    end else begin
      next_st.idle_cnt = '0;
    end

    // Suspend and wake sequence
    unique case (st.lstate)
      UFEC_RUN: begin
        if (st.ctl[ufec_pkg::CTL_FORCE_SLEEP]) begin
          next_st.lstate      = UFEC_SLEEP;
          next_st.armed       = 1'b0;
          next_st.resume_seen = 1'b0;
        end
      end
      UFEC_SLEEP: begin
        next_st.armed = 1'b0;
        if (!idle_s) begin
          set_ev[ufec_pkg::FLAG_SLEEP_END] = 1'b1;
          next_st.resume_seen = k_s;
          next_st.ctl[ufec_pkg::CTL_FORCE_SLEEP] = 1'b0;
          next_st.lstate = UFEC_WAKE;
        end else if (!st.ctl[ufec_pkg::CTL_FORCE_SLEEP]) begin
          next_st.lstate = UFEC_WAKE;
        end
      end
      UFEC_WAKE: begin
        // A software set of force-sleep in the wake cycle wins over the clear
        if (wr_ctl) begin
          next_st.ctl[ufec_pkg::CTL_FORCE_SLEEP] = pwdata[ufec_pkg::CTL_FORCE_SLEEP];
        end
        if (idle_s && !st.ctl[ufec_pkg::CTL_RESUME]) begin
          next_st.lstate = UFEC_RUN;
          next_st.armed  = 1'b1;
        end
      end
      default: begin
        // Unused code: return to run, with the armed bit kept as it was
        next_st.lstate = UFEC_RUN;
      end
    endcase

    // A link reset re-arms detection unless force-sleep is set, and always wipes the address
    if (link_rst) begin
      next_st.addr     = 7'h00;
      next_st.armed    = !st.ctl[ufec_pkg::CTL_FORCE_SLEEP];
      next_st.idle_cnt = '0;
      if (st.lstate == UFEC_WAKE) begin
        next_st.lstate = UFEC_RUN;
      end
    end

    next_st.flags = next_st.flags | set_ev;

    // Regulator settle time after it is switched back on
    // Ready is only a hint to software; it gates nothing on the link
    if (st.ctl[ufec_pkg::CTL_REG_OFF]) begin
      next_st.settle_cnt = '0;
    end else if (st.settle_cnt != SETTLE_LAST) begin
      next_st.settle_cnt = st.settle_cnt + SET_W'(1);
    end

    // Sleep-end goes to its own vector so it can wake a halted core
    next_st.wake_irq = next_st.flags[ufec_pkg::FLAG_SLEEP_END] &&
                       next_st.mask[ufec_pkg::FLAG_SLEEP_END] && !cpu_irq_disable;
    next_st.irq = (|({any_ok, 1'b0, next_st.flags} & next_st.mask &
                     ~(8'h01 << ufec_pkg::FLAG_SLEEP_END))) && !cpu_irq_disable;

    // Read data captured in the setup phase so it comes from a flop
    if (setup_rd) begin
      next_st.rdata = 32'h0000_0000;
      unique case (paddr)
        ufec_pkg::OFF_EVENT_FLAGS: next_st.rdata[7:0] = flags_view;
        ufec_pkg::OFF_EVENT_MASK:  next_st.rdata[7:0] = st.mask;
        ufec_pkg::OFF_LINK_CTRL:   next_st.rdata[7:0] = ctl_view;
        ufec_pkg::OFF_DEV_ADDR:    next_st.rdata[7:0] = {1'b0, st.addr};
        ufec_pkg::OFF_LAST_STATUS: next_st.rdata[7:0] = st.status;
        ufec_pkg::OFF_FAULT_TYPE:  next_st.rdata[7:0] = {5'b00000, st.fault};
        default:                   next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // The idle line rests high; zero here would fake a wake after reset
      st.idle_sync   <= 2'h3;
      st.k_sync      <= 2'h0;
      st.se0_sync    <= 2'h0;
      st.flags       <= ufec_pkg::RST_EVENT_FLAGS[5:0];
      st.mask        <= ufec_pkg::RST_EVENT_MASK;
      st.ctl         <= ufec_pkg::RST_LINK_CTRL[3:0];
      st.resume_seen <= 1'b0;
      st.addr        <= ufec_pkg::RST_DEV_ADDR[6:0];
      st.status      <= ufec_pkg::RST_LAST_STATUS;
      st.fault       <= ufec_pkg::RST_FAULT_TYPE[2:0];
      st.armed       <= 1'b0;
      st.idle_cnt    <= '0;
      st.settle_cnt  <= '0;
      st.lstate      <= UFEC_RUN;
      st.rdata       <= 32'h0000_0000;
      st.ok_set      <= 1'b0;
      st.ok_ep       <= 3'h0;
      st.ok_dir_in   <= 1'b0;
      st.irq         <= 1'b0;
      st.wake_irq    <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Zero wait states; unmapped offsets answer with an error and read zero
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = st.rdata;

  assign link.drive_resume  = st.ctl[ufec_pkg::CTL_RESUME];
  assign link.regulator_off = st.ctl[ufec_pkg::CTL_REG_OFF];
  assign link.suspend       = st.lstate == UFEC_SLEEP;
  assign link.link_reset    = st.ctl[ufec_pkg::CTL_FORCE_RESET];

  assign device_address   = st.addr;
  assign regulator_ready  = st.settle_cnt == SETTLE_LAST;
  assign ok_set           = st.ok_set;
  assign ok_ep            = st.ok_ep;
  assign ok_dir_in        = st.ok_dir_in;
  assign irq_request      = st.irq;
  assign wake_irq_request = st.wake_irq;

endmodule

// [rtl/ufec_pkg.sv]
// Shared constants and carrier types of the USB function event and control block
package ufec_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB side
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] OFF_EVENT_MASK  = 8'h04;
  localparam logic [7:0] OFF_LINK_CTRL   = 8'h08;
  localparam logic [7:0] OFF_DEV_ADDR    = 8'h0C;
  localparam logic [7:0] OFF_LAST_STATUS = 8'h10;
  localparam logic [7:0] OFF_FAULT_TYPE  = 8'h14;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_EVENT_FLAGS = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK  = 8'h00;
  localparam logic [7:0] RST_LINK_CTRL   = 8'h06;
  localparam logic [7:0] RST_DEV_ADDR    = 8'h00;
  localparam logic [7:0] RST_LAST_STATUS = 8'h00;
  localparam logic [7:0] RST_FAULT_TYPE  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Bit positions of event flags, mask and link control
  localparam int FLAG_XFER_OK   = 7;
  localparam int FLAG_SETUP_OVR = 5;
  localparam int FLAG_FAULT     = 4;
  localparam int FLAG_SLEEP_REQ = 3;
  localparam int FLAG_SLEEP_END = 2;
  localparam int FLAG_BUS_RESET = 1;
  localparam int FLAG_SOF       = 0;
  localparam int CTL_RESUME_SEEN = 7;
  localparam int CTL_RESET_SEEN  = 6;
  localparam int CTL_RESUME      = 3;
  localparam int CTL_REG_OFF     = 2;
  localparam int CTL_FORCE_SLEEP = 1;
  localparam int CTL_FORCE_RESET = 0;
  localparam logic [7:0] MASK_WRITABLE = 8'hBF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS      = 100;
  localparam int SUSPEND_IDLE_NS    = 3000000;
  localparam int SUSPEND_IDLE_CYC   = SUSPEND_IDLE_NS / CLK_PERIOD_NS;
  localparam int REG_SETTLE_NS      = 3000;
  localparam int REG_SETTLE_CYC     = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [2:0] EP_CONTROL   = 3'h0;
  localparam logic [2:0] EP_LAST      = 3'h5;
  localparam logic [1:0] PID_SETUP_HI = 2'h3;
  localparam logic [2:0] FAULT_NONE   = 3'h0;
  localparam logic [2:0] FAULT_STUFF  = 3'h1;
  localparam logic [2:0] FAULT_CRC    = 3'h2;
  localparam logic [2:0] FAULT_EOP    = 3'h3;
  localparam logic [2:0] FAULT_PID    = 3'h4;
  localparam logic [2:0] FAULT_MEM    = 3'h5;
  localparam logic [2:0] FAULT_OTHER  = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers from the serial engine and to the link
  typedef struct packed {
    logic       done;
    logic [2:0] ep;
    logic       dir_in;
    logic [1:0] pid_hi;
    logic       toggle_ok;
    logic       acked;
  } ufec_xfer_t;

  typedef struct packed {
    logic stuff;
    logic crc;
    logic eop;
    logic pid;
    logic mem;
    logic timeout;
  } ufec_err_t;

  typedef struct packed {
    logic drive_resume;
    logic regulator_off;
    logic suspend;
    logic link_reset;
  } ufec_link_t;

endpackage

// [verification/ufec_monitor.sv]
// Checker of the USB function event and control block
`timescale 1ns/1ps
module ufec_monitor #(
  parameter int NUM_OK_FLAGS = 7
) (
  input wire logic                    ref_clk,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire ufec_pkg::ufec_xfer_t    xfer,
  input wire ufec_pkg::ufec_err_t     bus_err,
  input wire logic                    bus_reset_seen,
  input wire logic [NUM_OK_FLAGS-1:0] ep_ok_flags,
  input wire logic                    line_idle,
  input wire logic                    cpu_irq_disable,
  input wire ufec_pkg::ufec_link_t    link,
  input wire logic [6:0]              device_address,
  input wire logic                    regulator_ready,
  input wire logic                    ok_set,
  input wire logic [2:0]              ok_ep,
  input wire logic                    ok_dir_in,
  input wire logic                    irq_request,
  input wire logic                    wake_irq_request
);
  logic good, ovr, unmapped, ctl_wr;
  assign good = xfer.done && xfer.acked && xfer.toggle_ok && bus_err == '0;
  // A setup overrun leaves the status alone, so it is kept out of the pulse check
  assign ovr = xfer.ep == 3'h0 && xfer.pid_hi == 2'h3 && ep_ok_flags[0];
  assign unmapped = paddr > 8'h14 || paddr[1:0] != 2'h0;
  assign ctl_wr = psel && penable && pwrite && paddr == ufec_pkg::OFF_LINK_CTRL;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  chk_ok_pulse: assert property (good && !ovr |=> ok_set && ok_ep == $past(xfer.ep))
    else $error("correct transfer not reported");
  chk_bad_xfer: assert property (xfer.done && !good |=> !ok_set)
    else $error("faulty transfer reported as correct");
  chk_ok_dir: assert property (good && !ovr && xfer.ep != 3'h0 |=> ok_dir_in == $past(xfer.dir_in))
    else $error("transfer direction lost");
  chk_irq_off: assert property (cpu_irq_disable && $past(cpu_irq_disable) |->
    !irq_request && !wake_irq_request)
    else $error("interrupt raised while disabled");
  chk_reset_addr: assert property (bus_reset_seen |-> ##[1:2] device_address == 7'h00)
    else $error("bus reset kept the address");
  chk_held_addr: assert property (link.link_reset && $past(link.link_reset) |-> device_address == 7'h00)
    else $error("address not held in forced reset");
  chk_resume_sw: assert property ($changed(link.drive_resume) |-> $past(ctl_wr))
    else $error("resume drive changed without a write");
  chk_reg_settle: assert property ($fell(link.regulator_off) |-> !regulator_ready [*8])
    else $error("regulator ready too early");
  chk_wake_exit: assert property (link.suspend && $fell(line_idle) |-> ##[1:6] !link.suspend)
    else $error("bus activity did not end suspend");
  chk_slave_resp: assert property (psel && penable |-> pready && pslverr == unmapped)
    else $error("slave response wrong");
endmodule

bind ufec_event_control ufec_monitor #(.NUM_OK_FLAGS(NUM_OK_FLAGS)) mon (.ref_clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pready, .pslverr, .xfer, .bus_err, .bus_reset_seen, .ep_ok_flags, .line_idle, .cpu_irq_disable, .link,
  .device_address, .regulator_ready, .ok_set, .ok_ep, .ok_dir_in, .irq_request, .wake_irq_request);

// [verification/ufec_host_model.sv]
// Behavioural model of the host traffic as seen through the serial engine
`timescale 1ns/1ps
module ufec_host_model (
  input  wire logic            ref_clk,
  output ufec_pkg::ufec_xfer_t xfer,
  output ufec_pkg::ufec_err_t  bus_err,
  output logic                 sof_seen,
  output logic                 bus_reset_seen,
  output logic                 line_idle,
  output logic                 line_k,
  output logic                 line_se0
);
  initial begin
    {xfer, bus_err, sof_seen, bus_reset_seen, line_k, line_se0} = '0;
    line_idle = 1'b1;
  end
  // Qualifiers are scrambled once done falls, so stale fields are never trusted
  task automatic send(input ufec_pkg::ufec_xfer_t x, input ufec_pkg::ufec_err_t e, input logic s, input logic r);
    xfer <= x;
    bus_err <= e;
    sof_seen <= s;
    bus_reset_seen <= r;
    @(posedge ref_clk);
    xfer <= {1'b0, ~x[7:0]};
    bus_err <= '0;
    sof_seen <= 1'b0;
    bus_reset_seen <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic set_line(input logic idle, input logic k, input logic se0);
    line_idle <= idle;
    line_k <= k;
    line_se0 <= se0;
  endtask
endmodule

// [verification/testbench.sv]
// Self-checking testbench of the USB function event and control block
`timescale 1ns/1ps
module testbench;
  localparam int IDLE = 20;
  localparam logic [7:0] A_FLG = ufec_pkg::OFF_EVENT_FLAGS, A_MSK = ufec_pkg::OFF_EVENT_MASK,
                         A_CTL = ufec_pkg::OFF_LINK_CTRL, A_ADR = ufec_pkg::OFF_DEV_ADDR,
                         A_STS = ufec_pkg::OFF_LAST_STATUS, A_FLT = ufec_pkg::OFF_FAULT_TYPE;
  logic                 ref_clk, rst, psel, penable, pwrite, pready, pslverr, sof_seen, bus_reset_seen;
  logic                 line_idle, line_k, line_se0, cpu_irq_disable, regulator_ready, ok_set, ok_dir_in;
  logic                 irq_request, wake_irq_request;
  logic [7:0]           paddr, st;
  logic [31:0]          pwdata, prdata, q;
  logic [6:0]           ep_ok_flags, device_address;
  logic [2:0]           ok_ep;
  ufec_pkg::ufec_xfer_t xfer, x;
  ufec_pkg::ufec_err_t  bus_err, e;
  ufec_pkg::ufec_link_t link;
  int                   mismatches, num_checks, cycles, seed;

  ufec_event_control #(.IDLE_CYCLES(IDLE), .NUM_OK_FLAGS(7)) uut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .xfer, .bus_err, .sof_seen, .bus_reset_seen, .ep_ok_flags, .line_idle,
    .line_k, .line_se0, .cpu_irq_disable, .link, .device_address, .regulator_ready, .ok_set, .ok_ep, .ok_dir_in,
    .irq_request, .wake_irq_request);
  ufec_host_model host (.ref_clk, .xfer, .bus_err, .sof_seen, .bus_reset_seen, .line_idle, .line_k, .line_se0);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One idle edge after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, $random(seed));
    chk(q, {24'h0, exp});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  function automatic logic [7:0] status_exp(input ufec_pkg::ufec_xfer_t t);
    return (t.ep == 3'h0) ? {t.pid_hi, 3'h0, t.ep} : {2'h0, t.dir_in, 2'h0, t.ep};
  endfunction
  function automatic logic [7:0] fault_exp(input ufec_pkg::ufec_err_t f);
    return f.stuff ? 8'h01 : f.crc ? 8'h02 : f.eop ? 8'h03 : f.pid ? 8'h04 : f.mem ? 8'h05 : 8'h07;
  endfunction
  task automatic xfer_rand(input logic tog, input logic ack);
    x = ufec_pkg::ufec_xfer_t'(9'($random(seed)));
    x.done = 1'b1;
    x.ep = 3'($unsigned($random(seed)) % 6);
    x.toggle_ok = tog;
    x.acked = ack;
    if (x.ep == 3'h0 && x.pid_hi == 2'h1) x.pid_hi = 2'h3;
    host.send(x, '0, 1'b0, 1'b0);
    if (tog && ack) st = status_exp(x);
    rd(A_STS, st);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h5BE203B3;
    {mismatches, num_checks, cycles} = '0;
    {rst, psel, penable, pwrite, cpu_irq_disable} = 5'h10;
    paddr = 8'h00;
    pwdata = 32'h0;
    ep_ok_flags = 7'h00;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) rd(8'(i * 4), (i == 2) ? ufec_pkg::RST_LINK_CTRL : 8'h00);
    rd(8'h18, 8'h00);
    wr(A_FLG, 8'hFF);
    rd(A_FLG, 8'h00);
    wr(A_MSK, 8'h04);
    host.set_line(1'b0, 1'b1, 1'b0);
    wait_cyc(8);
    chk({wake_irq_request, irq_request}, 2'b10);
    rd(A_FLG, 8'h04);
    rd(A_CTL, 8'h84);
    host.set_line(1'b1, 1'b0, 1'b0);
    wr(A_FLG, 8'hFB);
    wait_cyc(IDLE + 10);
    rd(A_FLG, 8'h08);
    wr(A_FLG, 8'hF7);
    wait_cyc(IDLE + 10);
    rd(A_FLG, 8'h00);
    wr(A_CTL, 8'h02);
    wait_cyc(IDLE + 14);
    rd(A_FLG, 8'h00);
    chk({link.suspend, regulator_ready}, 2'b11);
    host.set_line(1'b0, 1'b0, 1'b1);
    wait_cyc(6);
    chk(link.suspend, 1'b0);
    apb(1'b0, A_CTL, 32'h0);
    chk(q & 32'h7F, 32'h40);
    host.set_line(1'b0, 1'b0, 1'b0);
    wr(A_FLG, 8'h00);
    wr(A_CTL, 8'h0C);
    wait_cyc(2);
    chk({link.drive_resume, link.regulator_off, regulator_ready}, 3'b110);
    wr(A_CTL, 8'h00);
    wait_cyc(24);
    chk(regulator_ready, 1'b0);
    wait_cyc(8);
    chk(regulator_ready, 1'b1);
    wr(A_MSK, 8'hFF);
    rd(A_MSK, 8'hBF);
    wr(A_MSK, 8'h01);
    host.send('0, '0, 1'b1, 1'b0);
    rd(A_FLG, 8'h01);
    chk(irq_request, 1'b1);
    cpu_irq_disable <= 1'b1;
    wait_cyc(2);
    chk(irq_request, 1'b0);
    cpu_irq_disable <= 1'b0;
    wr(A_FLG, 8'hFE);
    rd(A_FLG, 8'h00);
    ep_ok_flags <= 7'($random(seed)) | 7'h01;
    wr(A_FLG, 8'h7F);
    rd(A_FLG, 8'h80);
    ep_ok_flags <= 7'h00;
    rd(A_FLG, 8'h00);
    st = 8'h00;
    for (int i = 0; i < 14; i++) xfer_rand(i % 5 != 3, i % 7 != 4);
    ep_ok_flags <= 7'h01;
    host.send(ufec_pkg::ufec_xfer_t'(9'h10F), '0, 1'b0, 1'b0);
    rd(A_FLG, 8'hA0);
    rd(A_STS, st);
    ep_ok_flags <= 7'h00;
    wr(A_FLG, 8'hDF);
    for (int i = 0; i < 9; i++) begin
      e = ufec_pkg::ufec_err_t'((i < 6) ? 6'h20 >> i : 6'($random(seed)) | 6'h01);
      host.send('0, e, 1'b0, 1'b0);
      rd(A_FLT, fault_exp(e));
      rd(A_FLG, 8'h10);
      wr(A_FLG, 8'hEF);
      rd(A_FLT, 8'h00);
    end
    wr(A_ADR, 8'hFF);
    rd(A_ADR, 8'h7F);
    host.send('0, '0, 1'b0, 1'b1);
    rd(A_ADR, 8'h00);
    rd(A_FLG, 8'h02);
    wr(A_MSK, 8'h02);
    wr(A_FLG, 8'hFD);
    wr(A_ADR, 8'h35);
    wr(A_CTL, 8'h01);
    chk(link.link_reset, 1'b1);
    rd(A_ADR, 8'h00);
    wr(A_CTL, 8'h00);
    rd(A_FLG, 8'h02);
    chk(irq_request, 1'b1);
    end_of_test();
  end
endmodule
